// File: hw/vres_event_select.sv
// Vertical ring event selection and qualification for one mesh stop.
`timescale 1ns/1ps
`include "vres_consts.svh"
module vres_event_select (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Counter control
    input wire logic enable,
    input wire logic counter_clear,
    input wire logic [7:0] event_code,
    input wire logic [7:0] unit_mask,
    // Stop placement
    input wire logic [`VRES_STOP_W-1:0] stop_index,
    input wire logic [`VRES_STOP_W-1:0] stop_count,
    // Starvation sources, set0: req a0, ack a0, data a0, inv a0, req a1, ack a1, data a1
    input wire logic [6:0] vertical_egress_starvation_set0,
    // Starvation sources, set1: ack credit a0, ack credit a1, tag ring
    input wire logic [2:0] vertical_egress_starvation_set1,
    // Ring pass/sink occupancy per physical ring and slot parity
    input wire vres_pkg::vres_ring_use_t request_ring_use,
    input wire vres_pkg::vres_ring_use_t ack_ring_busy_in,
    input wire vres_pkg::vres_ring_use_t ack_credit_ring_use,
    input wire vres_pkg::vres_ring_use_t data_ring_use,
    input wire vres_pkg::vres_ring_use_t tag_ring_use,
    // Invalidate ring: [0] up, [1] down as seen at this stop
    input wire logic [1:0] invalidate_ring_use,
    // Injection by this stop, per ring (req, ack, ack credit, data, inv, tag)
    input wire logic [5:0] local_inject,
    // Outputs
    output logic event_hit_reg,
    output logic on_right_side_reg,
    output logic [`VRES_CNT_W-1:0] event_count_reg
);
    // ==========================================================
    // Side of the ring
    // ==========================================================
    // Placement is registered; it changes only at configuration time,
    // so one cycle of lag after a change is harmless.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            on_right_side_reg <= 1'b0;
        end else begin
            on_right_side_reg <= ({1'b0, stop_index} << 1) >= {1'b0, stop_count};
        end
    end

    // Remap a physical cw/ccw occupancy vector to up/down labels.
    function automatic vres_pkg::vres_ring_use_t to_updown(
        input vres_pkg::vres_ring_use_t phys, input logic right);
        to_updown = right ? {phys[1:0], phys[3:2]} : phys;
    endfunction

    // Decode the four direction/parity mask bits against an up/down vector.
    function automatic logic dir_hit(input vres_pkg::vres_ring_use_t ud,
        input logic [7:0] m, input logic inj);
        dir_hit = !inj && (
            (m[`VRES_BIT_UP_EVEN] && ud[0]) || (m[`VRES_BIT_UP_ODD] && ud[1]) ||
            (m[`VRES_BIT_DESCENDING_EVEN_SLOT] && ud[2]) || (m[`VRES_BIT_DESCENDING_ODD_SLOT] && ud[3]));
    endfunction

    // ==========================================================
    // Event selection
    // ==========================================================
    logic hit_next;
    always_comb begin
        hit_next = 1'b0;
        if (event_code == `VRES_CODE_STARVED0) begin
            hit_next = |(unit_mask[6:0] & vertical_egress_starvation_set0);
        end else if (event_code == `VRES_CODE_STARVED1) begin
            hit_next = |(unit_mask[2:0] & vertical_egress_starvation_set1);
        end else if (event_code == `VRES_CODE_REQ_BUSY) begin
            hit_next = dir_hit(to_updown(request_ring_use, on_right_side_reg),
                unit_mask, local_inject[0]);
        end else if (event_code == `VRES_CODE_ACK_BUSY) begin
            hit_next = dir_hit(to_updown(ack_ring_busy_in, on_right_side_reg),
                unit_mask, local_inject[1]);
        end else if (event_code == `VRES_CODE_ACKC_BUSY) begin
            hit_next = dir_hit(to_updown(ack_credit_ring_use, on_right_side_reg),
                unit_mask, local_inject[2]);
        end else if (event_code == `VRES_CODE_DATA_BUSY) begin
            hit_next = dir_hit(to_updown(data_ring_use, on_right_side_reg),
                unit_mask, local_inject[3]);
        end else if (event_code == `VRES_CODE_INV_BUSY) begin
            // Single ring: bit 0 up, bit 2 down; odd bits have no meaning here.
            hit_next = !local_inject[4] && ((unit_mask[`VRES_BIT_UP_EVEN] &&
                invalidate_ring_use[0]) || (unit_mask[`VRES_BIT_DESCENDING_EVEN_SLOT] &&
                invalidate_ring_use[1]));
        end else if (event_code == `VRES_CODE_TAG_BUSY) begin
            hit_next = dir_hit(to_updown(tag_ring_use, on_right_side_reg),
                unit_mask, local_inject[5]);
        end
    end

    // ==========================================================
    // Counting
    // ==========================================================
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            event_hit_reg <= 1'b0;
        end else begin
            event_hit_reg <= enable && hit_next;
        end
    end

    vres_sel_if link ();
    assign link.hit = event_hit_reg;
    assign link.clr = counter_clear;

    vres_counter u_counter (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .sel(link.cnt),
        .count(event_count_reg)
    );

    // ==========================================================
    // Checks
    // ==========================================================
    a_starve0_hit: assert property (@(posedge sys_clk) disable iff (!rstn)
        (enable && event_code == `VRES_CODE_STARVED0) |=>
        event_hit_reg == |($past(unit_mask[6:0]) & $past(vertical_egress_starvation_set0)))
        else $error("set0 starvation hit wrong");
    a_starve1_hit: assert property (@(posedge sys_clk) disable iff (!rstn)
        (enable && event_code == `VRES_CODE_STARVED1) |=>
        event_hit_reg == |($past(unit_mask[2:0]) & $past(vertical_egress_starvation_set1)))
        else $error("set1 starvation hit wrong");
    a_req_inject: assert property (@(posedge sys_clk) disable iff (!rstn)
        (event_code == `VRES_CODE_REQ_BUSY && local_inject[0]) |=> !event_hit_reg)
        else $error("request ring counted an injection cycle");
    a_left_upeven: assert property (@(posedge sys_clk) disable iff (!rstn)
        (enable && event_code == `VRES_CODE_DATA_BUSY && !on_right_side_reg &&
        !local_inject[3] && unit_mask[3:0] == 4'h1 && data_ring_use[0]) |=> event_hit_reg)
        else $error("up-even on the left side missed");
    a_right_swap: assert property (@(posedge sys_clk) disable iff (!rstn)
        (enable && event_code == `VRES_CODE_ACK_BUSY && on_right_side_reg &&
        unit_mask[3:0] == 4'h1 && ack_ring_busy_in == 4'h1) |=> !event_hit_reg)
        else $error("right side did not reverse directions");
    a_side_split: assert property (@(posedge sys_clk) disable iff (!rstn)
        (stop_count == `VRES_STOP_W'(4) && stop_index == `VRES_STOP_W'(2)) |=> on_right_side_reg)
        else $error("second half stop not on the right");
    a_ackc_inject: assert property (@(posedge sys_clk) disable iff (!rstn)
        (event_code == `VRES_CODE_ACKC_BUSY && local_inject[2]) |=> !event_hit_reg)
        else $error("ack credit ring counted an injection");
    a_inv_down: assert property (@(posedge sys_clk) disable iff (!rstn)
        (enable && event_code == `VRES_CODE_INV_BUSY && !local_inject[4] &&
        unit_mask[2] && invalidate_ring_use[1]) |=> event_hit_reg)
        else $error("invalidate down cycle missed");
    a_tag_inject: assert property (@(posedge sys_clk) disable iff (!rstn)
        (event_code == `VRES_CODE_TAG_BUSY && local_inject[5]) |=> !event_hit_reg)
        else $error("tag ring counted an injection");
    a_disabled_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
        !enable |=> !event_hit_reg)
        else $error("hit while disabled");

    // ==========================================================
    // Direction and parity checks
    // ==========================================================
    // Left side: the labels equal the physical rings, up on the clockwise one.
    a_left_dnodd: assert property (@(posedge sys_clk) disable iff (!rstn)
        (enable && event_code == `VRES_CODE_REQ_BUSY && !on_right_side_reg &&
        !local_inject[0] && unit_mask[3:0] == 4'h8 && request_ring_use[3]) |=> event_hit_reg)
        else $error("down-odd on the left side missed");
    a_left_upodd: assert property (@(posedge sys_clk) disable iff (!rstn)
        (enable && event_code == `VRES_CODE_ACK_BUSY && !on_right_side_reg &&
        !local_inject[1] && unit_mask[3:0] == 4'h2 && ack_ring_busy_in[1]) |=> event_hit_reg)
        else $error("up-odd on the left side missed");
    a_ackc_dneven: assert property (@(posedge sys_clk) disable iff (!rstn)
        (enable && event_code == `VRES_CODE_ACKC_BUSY && !on_right_side_reg &&
        !local_inject[2] && unit_mask[3:0] == 4'h4 && ack_credit_ring_use[2]) |=> event_hit_reg)
        else $error("ack credit down-even missed");
    a_data_dnodd: assert property (@(posedge sys_clk) disable iff (!rstn)
        (enable && event_code == `VRES_CODE_DATA_BUSY && !on_right_side_reg &&
        !local_inject[3] && unit_mask[3:0] == 4'h8 && data_ring_use[3]) |=> event_hit_reg)
        else $error("data ring down-odd missed");
    a_tag_upeven: assert property (@(posedge sys_clk) disable iff (!rstn)
        (enable && event_code == `VRES_CODE_TAG_BUSY && !on_right_side_reg &&
        !local_inject[5] && unit_mask[3:0] == 4'h1 && tag_ring_use[0]) |=> event_hit_reg)
        else $error("tag ring up-even missed");
    // Right side: up is the counter-clockwise ring, down the clockwise one.
    a_right_upeven: assert property (@(posedge sys_clk) disable iff (!rstn)
        (enable && event_code == `VRES_CODE_DATA_BUSY && on_right_side_reg &&
        !local_inject[3] && unit_mask[3:0] == 4'h1 && data_ring_use[2]) |=> event_hit_reg)
        else $error("right side up-even missed");
    a_right_dneven: assert property (@(posedge sys_clk) disable iff (!rstn)
        (enable && event_code == `VRES_CODE_DATA_BUSY && on_right_side_reg &&
        !local_inject[3] && unit_mask[3:0] == 4'h4 && data_ring_use[0]) |=> event_hit_reg)
        else $error("right side down-even missed");
    a_right_ackdn: assert property (@(posedge sys_clk) disable iff (!rstn)
        (enable && event_code == `VRES_CODE_ACK_BUSY && on_right_side_reg &&
        !local_inject[1] && unit_mask[3:0] == 4'h4 && ack_ring_busy_in[0]) |=> event_hit_reg)
        else $error("right side ack down-even missed");
    a_side_left: assert property (@(posedge sys_clk) disable iff (!rstn)
        (stop_count == `VRES_STOP_W'(4) && stop_index == `VRES_STOP_W'(1)) |=>
        !on_right_side_reg)
        else $error("first half stop not on the left");

    // ==========================================================
    // Selection checks
    // ==========================================================
    a_starve0_agent1: assert property (@(posedge sys_clk) disable iff (!rstn)
        (enable && event_code == `VRES_CODE_STARVED0 && unit_mask[6] &&
        vertical_egress_starvation_set0[6]) |=> event_hit_reg)
        else $error("agent 1 data starvation missed");
    a_starve1_tag: assert property (@(posedge sys_clk) disable iff (!rstn)
        (enable && event_code == `VRES_CODE_STARVED1 && unit_mask[2] &&
        vertical_egress_starvation_set1[2]) |=> event_hit_reg)
        else $error("tag ring starvation missed");
    a_ack_inject: assert property (@(posedge sys_clk) disable iff (!rstn)
        (event_code == `VRES_CODE_ACK_BUSY && local_inject[1]) |=> !event_hit_reg)
        else $error("ack ring counted an injection");
    a_data_inject: assert property (@(posedge sys_clk) disable iff (!rstn)
        (event_code == `VRES_CODE_DATA_BUSY && local_inject[3]) |=> !event_hit_reg)
        else $error("data ring counted an injection");
    a_inv_inject: assert property (@(posedge sys_clk) disable iff (!rstn)
        (event_code == `VRES_CODE_INV_BUSY && local_inject[4]) |=> !event_hit_reg)
        else $error("invalidate ring counted an injection");
    a_inv_up: assert property (@(posedge sys_clk) disable iff (!rstn)
        (enable && event_code == `VRES_CODE_INV_BUSY && !local_inject[4] &&
        unit_mask[0] && invalidate_ring_use[0]) |=> event_hit_reg)
        else $error("invalidate up cycle missed");
    a_inv_odd_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
        (event_code == `VRES_CODE_INV_BUSY && !unit_mask[0] && !unit_mask[2]) |=> !event_hit_reg)
        else $error("invalidate counted without a direction bit");
    a_unknown_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
        !(event_code inside {`VRES_CODE_STARVED0, `VRES_CODE_STARVED1, `VRES_CODE_REQ_BUSY,
        `VRES_CODE_ACK_BUSY, `VRES_CODE_DATA_BUSY, `VRES_CODE_INV_BUSY,
        `VRES_CODE_ACKC_BUSY, `VRES_CODE_TAG_BUSY}) |=> !event_hit_reg)
        else $error("hit on an unknown event code");
endmodule

// File: pkg/vres_consts.svh
// Constants for the vertical ring event select block.
// Operation
// - Code 9A counts starvation, seven ring/agent bits.
// - Code 9B counts credit and tag starvation.
// - Code B0 counts request ring pass/sink cycles.
// - Mask bits: up-even, up-odd, down-even, down-odd.
// - Left stops: up clockwise; right stops reversed.
// - First half of stops left, rest right.
// - Code B4 counts ack-credit ring busy cycles.
// - Code B1 counts ack ring busy cycles.
// - Code B2 counts data ring busy cycles.
// - Code B3 invalidate ring, bit0 up, bit2 down.
// - Code B5 counts tag ring busy cycles.
`ifndef VRES_CONSTS_SVH
`define VRES_CONSTS_SVH
`define VRES_CODE_STARVED0 8'h9A
`define VRES_CODE_STARVED1 8'h9B
`define VRES_CODE_REQ_BUSY 8'hB0
`define VRES_CODE_ACK_BUSY 8'hB1
`define VRES_CODE_DATA_BUSY 8'hB2
`define VRES_CODE_INV_BUSY 8'hB3
`define VRES_CODE_ACKC_BUSY 8'hB4
`define VRES_CODE_TAG_BUSY 8'hB5
`define VRES_BIT_UP_EVEN 0
`define VRES_BIT_UP_ODD 1
`define VRES_BIT_DESCENDING_EVEN_SLOT 2
`define VRES_BIT_DESCENDING_ODD_SLOT 3
`define VRES_CNT_W 48
`define VRES_STOP_W 6
`endif

// File: pkg/vres_pkg.sv
// Types for the vertical ring event select block.
package vres_pkg;
    // Per-ring occupancy: [0]=cw even, [1]=cw odd, [2]=ccw even, [3]=ccw odd.
    typedef logic [3:0] vres_ring_use_t;
    typedef enum logic [1:0] {VRES_IDLE, VRES_COUNT} vres_state_t;
endpackage

// File: pkg/vres_sel_if.sv
// Interface between the event selector and the counter.
`timescale 1ns/1ps
interface vres_sel_if;
    logic hit;
    logic clr;
    modport sel (output hit, output clr);
    modport cnt (input hit, input clr);
endinterface

// File: hw/vres_counter.sv
// Event counter that adds one per qualifying cycle.
`timescale 1ns/1ps
`include "vres_consts.svh"
module vres_counter (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Selector side
    vres_sel_if.cnt sel,
    // Count value
    output logic [`VRES_CNT_W-1:0] count
);
    always_ff @(posedge sys_clk) begin
        if (!rstn || sel.clr) begin
            count <= '0;
        end else if (sel.hit) begin
            count <= count + `VRES_CNT_W'(1);
        end
    end

    a_count_step: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!sel.clr && sel.hit) |=> count == $past(count) + `VRES_CNT_W'(1))
        else $error("counter did not step on a hit");
    a_count_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!sel.clr && !sel.hit) |=> $stable(count))
        else $error("counter moved without a hit");
    a_count_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
        sel.clr |=> count == '0)
        else $error("counter did not clear");
endmodule

// File: verif/vres_event_select_test.sv
// Self-checking bench for the vertical ring event select block.
`timescale 1ns/1ps
`include "vres_consts.svh"
module vertical_ring_event_select_test;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic enable = 1'b0;
    logic counter_clear = 1'b0;
    logic [7:0] event_code = 8'h00;
    logic [7:0] unit_mask = 8'h00;
    logic [`VRES_STOP_W-1:0] stop_index = 6'h00;
    logic [`VRES_STOP_W-1:0] stop_count = 6'h08;
    logic [6:0] starve0 = 7'h00;
    logic [2:0] starve1 = 3'h0;
    // Order: request, ack, ack credit, data, tag.
    vres_pkg::vres_ring_use_t ring_use [5] = '{default: 4'h0};
    logic [1:0] inv_use = 2'h0;
    logic [5:0] inject = 6'h00;
    logic event_hit_reg;
    logic on_right_side_reg;
    logic [`VRES_CNT_W-1:0] event_count_reg;
    logic [7:0] codes [5] = '{8'hB0, 8'hB1, 8'hB4, 8'hB2, 8'hB5};
    int inj_bit [5] = '{0, 1, 2, 3, 5};
    int fail_count = 0;
    int n_tests = 0;

    always #2 sys_clk = ~sys_clk;

    vres_event_select u_vres_event_select (
        .sys_clk(sys_clk), .rstn(rstn), .enable(enable), .counter_clear(counter_clear),
        .event_code(event_code), .unit_mask(unit_mask), .stop_index(stop_index),
        .stop_count(stop_count), .vertical_egress_starvation_set0(starve0),
        .vertical_egress_starvation_set1(starve1), .request_ring_use(ring_use[0]),
        .ack_ring_busy_in(ring_use[1]), .ack_credit_ring_use(ring_use[2]),
        .data_ring_use(ring_use[3]), .tag_ring_use(ring_use[4]),
        .invalidate_ring_use(inv_use), .local_inject(inject),
        .event_hit_reg(event_hit_reg), .on_right_side_reg(on_right_side_reg),
        .event_count_reg(event_count_reg)
    );

    task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
            fail_count++;
        end
    endtask

    // Called at a falling edge; the hit shows one cycle after the select.
    task automatic probe(input logic [7:0] code, input logic [7:0] mask, input logic exp);
        event_code = code;
        unit_mask = mask;
        @(negedge sys_clk);
        chk("event_hit_reg", exp, event_hit_reg);
    endtask

    task automatic t_starve();
        for (int i = 0; i < 7; i++) begin
            starve0 = 7'(8'h01 << i);
            probe(8'h9A, 8'h01 << i, 1'b1);
            probe(8'h9A, 8'h7F & ~(8'h01 << i), 1'b0);
        end
        starve0 = 7'h00;
        for (int i = 0; i < 3; i++) begin
            starve1 = 3'(8'h01 << i);
            probe(8'h9B, 8'h01 << i, 1'b1);
            probe(8'h9B, 8'h07 & ~(8'h01 << i), 1'b0);
        end
        starve1 = 3'h0;
    endtask

    task automatic t_rings();
        for (int r = 0; r < 5; r++) begin
            for (int b = 0; b < 4; b++) begin
                ring_use[r] = 4'h1 << b;
                probe(codes[r], 8'h01 << b, 1'b1);
                probe(codes[r], 8'h0F ^ (8'h01 << b), 1'b0);
                inject[inj_bit[r]] = 1'b1;
                probe(codes[r], 8'h01 << b, 1'b0);
                inject = 6'h00;
                ring_use[r] = 4'h0;
            end
        end
    endtask

    task automatic t_sides();
        stop_index = 6'h04;
        @(negedge sys_clk);
        chk("on_right_side_reg", 48'h1, on_right_side_reg);
        ring_use[3] = 4'h4;
        probe(8'hB2, 8'h01, 1'b1);
        ring_use[3] = 4'h1;
        probe(8'hB2, 8'h01, 1'b0);
        probe(8'hB2, 8'h04, 1'b1);
        ring_use[1] = 4'h1;
        probe(8'hB1, 8'h01, 1'b0);
        probe(8'hB1, 8'h04, 1'b1);
        ring_use[1] = 4'h0;
        stop_index = 6'h03;
        @(negedge sys_clk);
        chk("on_right_side_reg", 48'h0, on_right_side_reg);
        probe(8'hB2, 8'h01, 1'b1);
        stop_count = 6'h04;
        stop_index = 6'h02;
        @(negedge sys_clk);
        chk("on_right_side_reg", 48'h1, on_right_side_reg);
        probe(8'hB2, 8'h01, 1'b0);
        stop_index = 6'h01;
        @(negedge sys_clk);
        chk("on_right_side_reg", 48'h0, on_right_side_reg);
        probe(8'hB2, 8'h01, 1'b1);
        stop_count = 6'h08;
        stop_index = 6'h00;
        ring_use[3] = 4'h0;
    endtask

    task automatic t_inv();
        inv_use = 2'h1;
        probe(8'hB3, 8'h01, 1'b1);
        probe(8'hB3, 8'h02, 1'b0);
        probe(8'hB3, 8'h04, 1'b0);
        inv_use = 2'h2;
        probe(8'hB3, 8'h04, 1'b1);
        probe(8'hB3, 8'h08, 1'b0);
        inject[4] = 1'b1;
        probe(8'hB3, 8'h04, 1'b0);
        inject = 6'h00;
        inv_use = 2'h0;
    endtask

    // Two sub-events at once still add one per cycle; enable and clear gate it.
    task automatic t_count();
        counter_clear = 1'b1;
        @(negedge sys_clk);
        counter_clear = 1'b0;
        ring_use[3] = 4'h3;
        event_code = 8'hB2;
        unit_mask = 8'h03;
        repeat (5) @(negedge sys_clk);
        ring_use[3] = 4'h0;
        repeat (3) @(negedge sys_clk);
        chk("event_count_reg", 48'h5, event_count_reg);
        enable = 1'b0;
        ring_use[3] = 4'h3;
        repeat (4) @(negedge sys_clk);
        chk("event_hit_reg", 48'h0, event_hit_reg);
        chk("event_count_reg", 48'h5, event_count_reg);
        enable = 1'b1;
        counter_clear = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk("event_count_reg", 48'h0, event_count_reg);
        counter_clear = 1'b0;
        probe(8'h00, 8'hFF, 1'b0);
        ring_use[3] = 4'h0;
    endtask

    // A second reset in mid-run returns every output to zero, then counting resumes.
    task automatic t_reset();
        stop_index = 6'h04;
        ring_use[3] = 4'hF;
        event_code = 8'hB2;
        unit_mask = 8'h03;
        @(negedge sys_clk);
        rstn = 1'b0;
        @(negedge sys_clk);
        chk("event_hit_reg", 48'h0, event_hit_reg);
        chk("on_right_side_reg", 48'h0, on_right_side_reg);
        chk("event_count_reg", 48'h0, event_count_reg);
        rstn = 1'b1;
        @(negedge sys_clk);
        chk("event_hit_reg", 48'h1, event_hit_reg);
        chk("on_right_side_reg", 48'h1, on_right_side_reg);
        @(negedge sys_clk);
        chk("event_count_reg", 48'h1, event_count_reg);
        ring_use[3] = 4'h0;
        stop_index = 6'h00;
    endtask

    task automatic end_of_test();
        if (fail_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #40000;
        fail_count++;
        end_of_test();
    end

    initial begin
        repeat (8) @(negedge sys_clk);
        rstn = 1'b1;
        enable = 1'b1;
        chk("event_count_reg", 48'h0, event_count_reg);
        @(negedge sys_clk);
        t_starve();
        t_rings();
        t_sides();
        t_inv();
        t_count();
        t_reset();
        end_of_test();
    end
endmodule
